//--- design/ofpi_pkg.sv
// Purpose: Shared constants for the octal flash pin interface block.
// Assumes: One 100 MHz system clock samples every pin of the link.
// Notes:   Operation
package ofpi_pkg;
  localparam int         SYNC_STAGES   = 2;
  localparam int         BYTE_BITS     = 8;
  localparam logic [2:0] BIT_IDX_LAST  = 3'h7;
  localparam logic [2:0] BIT_IDX_RST   = 3'h0;
  localparam logic [7:0] OE_ALL_OFF    = 8'h00;
  localparam logic [7:0] OE_OCTAL      = 8'hff;
  localparam logic [7:0] OE_X1_SO      = 8'h02;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam int         SO_LINE       = 1;
  localparam int         SI_LINE       = 0;

  typedef enum logic [1:0] {
    OFPI_IDLE,
    OFPI_CAPTURE,
    OFPI_READ,
    OFPI_INIT
  } ofpi_state_e;
endpackage

//--- design/ofpi_sync.sv
// Purpose: Two-flop synchroniser for pins entering the system clock.
// Assumes: Inputs are asynchronous levels; rstn is synchronous.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module ofpi_sync
  import ofpi_pkg::*;
#(
  parameter int         WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage read only by the second
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- design/ofpi_core.sv
// Purpose: Device-side pin logic of an octal or x1 serial flash link.
// Assumes: Pins are oversampled by sys_clk, well above the link clock.
// Notes:   Core logic supplies read bytes and event pulses on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ofpi_core
  import ofpi_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Link pins in
  input  wire logic       select_n,
  input  wire logic       serial_clock,
  input  wire logic [7:0] dq_in,
  input  wire logic       hw_init_n,
  // Link pins out
  output logic      [7:0] dq_out,
  output logic      [7:0] dq_oe,
  output logic            read_strobe_out,
  output logic            read_strobe_oe,
  output logic            int_n_out,
  output logic            int_n_oe,
  // Core side mode and status
  input  wire logic       ddr_mode,
  input  wire logic       octal_mode,
  input  wire logic       op_busy,
  input  wire logic       event_in,
  input  wire logic       event_clear,
  // Core side data
  input  wire logic       read_start,
  input  wire logic [7:0] tx_byte,
  output logic            tx_take,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            txn_start,
  output logic            txn_end,
  output logic            standby,
  output logic            reinit
);
  logic [10:0] pins_s;
  logic        sel_n_s, clk_s, init_n_s, clk_d, sel_n_d;
  logic [7:0]  dq_s;
  logic        sel_fall, sel_rise, clk_rise, clk_fall, live;
  logic        cap_hit, launch_hit;
  ofpi_state_e state_reg;
  logic        ddr_reg, oct_reg;
  logic [2:0]  rx_idx_reg, tx_idx_reg;
  logic [7:0]  rx_shift_reg;

  // Chosen edge, plus the other edge in DDR
  function automatic logic edge_hit(input logic primary, input logic other,
                                    input logic ddr);
    edge_hit = primary | (ddr & other);
  endfunction

  // Initialisation pin resets to high like its pad pull-up
  ofpi_sync #(
    .WIDTH   (11),
    .RST_VAL (11'h600)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in ({hw_init_n, select_n, dq_in, serial_clock}),
    .sync_out (pins_s)
  );
  assign init_n_s = pins_s[10];
  assign sel_n_s  = pins_s[9];
  assign dq_s     = pins_s[8:1];
  assign clk_s    = pins_s[0];

  // Delayed copies for edge finding
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      clk_d   <= 1'b0;
      sel_n_d <= 1'b1;
    end else begin
      clk_d   <= clk_s;
      sel_n_d <= sel_n_s;
    end
  end

  assign sel_fall   = sel_n_d & ~sel_n_s;
  assign sel_rise   = ~sel_n_d & sel_n_s;
  assign clk_rise   = ~clk_d & clk_s;
  assign clk_fall   = clk_d & ~clk_s;
  // Pins matter only with select low and no initialisation
  assign live       = ~sel_n_s & init_n_s;
  assign cap_hit    = live & edge_hit(clk_rise, clk_fall, ddr_reg);
  assign launch_hit = live & edge_hit(clk_fall, clk_rise, ddr_reg);

  // Transaction sequencing; initialisation pin wins regardless of select
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= OFPI_IDLE;
    end else if (!init_n_s) begin
      state_reg <= OFPI_INIT;
    end else begin
      unique case (state_reg)
        OFPI_INIT:    state_reg <= OFPI_IDLE;
        OFPI_IDLE:    if (sel_fall) state_reg <= OFPI_CAPTURE;
        OFPI_CAPTURE: begin
          if (sel_rise) state_reg <= OFPI_IDLE;
          else if (read_start && live) state_reg <= OFPI_READ;
        end
        OFPI_READ:    if (sel_rise) state_reg <= OFPI_IDLE;
      endcase
    end
  end

  // Link format latched per transaction, so mid-frame changes cannot tear it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ddr_reg <= 1'b0;
      oct_reg <= 1'b0;
    end else if (sel_fall) begin
      ddr_reg <= ddr_mode & octal_mode;
      oct_reg <= octal_mode;
    end
  end

  // Framing pulses and status levels
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      txn_start <= 1'b0;
      txn_end   <= 1'b0;
      standby   <= 1'b1;
      reinit    <= 1'b0;
    end else begin
      txn_start <= sel_fall & init_n_s;
      txn_end   <= sel_rise & init_n_s;
      standby   <= sel_n_s & ~op_busy;
      reinit    <= ~init_n_s;
    end
  end

  // Inbound capture: x8 takes a byte per capture edge (rising only in SDR), x1 shifts line 0
  always_ff @(posedge sys_clk) begin
    if (!rstn || state_reg != OFPI_CAPTURE || !live) begin
      rx_idx_reg   <= BIT_IDX_RST;
      rx_shift_reg <= BYTE_RST;
      rx_valid     <= 1'b0;
      if (!rstn) rx_byte <= BYTE_RST;
    end else if (cap_hit) begin
      if (oct_reg) begin
        rx_byte  <= dq_s;
        rx_valid <= 1'b1;
      end else begin
        rx_shift_reg <= {rx_shift_reg[6:0], dq_s[SI_LINE]};
        rx_idx_reg   <= rx_idx_reg + 3'h1;
        rx_valid     <= (rx_idx_reg == BIT_IDX_LAST);
        if (rx_idx_reg == BIT_IDX_LAST) rx_byte <= {rx_shift_reg[6:0], dq_s[SI_LINE]};
      end
    end else begin
      rx_valid <= 1'b0;
    end
  end

  // Outbound launch with strobe toggling alongside each data change
  always_ff @(posedge sys_clk) begin
    if (!rstn || state_reg != OFPI_READ || !live) begin
      tx_idx_reg      <= BIT_IDX_RST;
      tx_take         <= 1'b0;
      dq_out          <= BYTE_RST;
      read_strobe_out <= 1'b0;
    end else if (launch_hit) begin
      read_strobe_out <= ~read_strobe_out;
      if (oct_reg) begin
        dq_out  <= tx_byte;
        tx_take <= 1'b1;
      end else begin
        dq_out          <= BYTE_RST;
        dq_out[SO_LINE] <= tx_byte[BIT_IDX_LAST - tx_idx_reg];
        tx_idx_reg      <= tx_idx_reg + 3'h1;
        tx_take         <= (tx_idx_reg == BIT_IDX_LAST);
      end
    end else begin
      tx_take <= 1'b0;
    end
  end

  // Drivers on only while reading in a live frame
  always_ff @(posedge sys_clk) begin
    if (!rstn || !live || state_reg != OFPI_READ) begin
      dq_oe          <= OE_ALL_OFF;
      read_strobe_oe <= 1'b0;
    end else begin
      dq_oe          <= oct_reg ? OE_OCTAL : OE_X1_SO;
      read_strobe_oe <= 1'b1;
    end
  end

  // Open drain: level fixed low, only the enable moves; set beats clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      int_n_out <= 1'b0;
      int_n_oe  <= 1'b0;
    end else if (event_in) begin
      int_n_oe  <= 1'b1;
    end else if (event_clear) begin
      int_n_oe  <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_start;
    sel_fall && init_n_s |=> txn_start ##1 !txn_start;
  endproperty
  a_start: assert property (p_start) else $error("start pulse missing");

  property p_standby;
    sel_n_s && !op_busy |=> standby;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not shown");

  property p_busy_active;
    op_busy |=> !standby;
  endproperty
  a_busy_active: assert property (p_busy_active) else $error("standby while busy");

  property p_hiz_sel;
    sel_n_s |=> dq_oe == OE_ALL_OFF && !read_strobe_oe;
  endproperty
  a_hiz_sel: assert property (p_hiz_sel) else $error("driving while deselected");

  property p_init;
    !init_n_s |=> state_reg == OFPI_INIT && reinit;
  endproperty
  a_init: assert property (p_init) else $error("init pin ignored");

  property p_init_hiz;
    !init_n_s |=> dq_oe == OE_ALL_OFF && !read_strobe_oe;
  endproperty
  a_init_hiz: assert property (p_init_hiz) else $error("driving during init");

  property p_sdr_cap;
    state_reg == OFPI_CAPTURE && live && oct_reg && !ddr_reg && clk_fall |=> !rx_valid;
  endproperty
  a_sdr_cap: assert property (p_sdr_cap) else $error("sdr captured on fall");

  property p_ddr_cap;
    state_reg == OFPI_CAPTURE && live && oct_reg && ddr_reg && clk_fall |=> rx_valid;
  endproperty
  a_ddr_cap: assert property (p_ddr_cap) else $error("ddr fall not captured");

  property p_strobe;
    state_reg == OFPI_READ && launch_hit |=> read_strobe_out != $past(read_strobe_out);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe did not toggle");

  property p_x1_oe;
    state_reg == OFPI_READ && live && !oct_reg |=> dq_oe == OE_X1_SO;
  endproperty
  a_x1_oe: assert property (p_x1_oe) else $error("x1 enables wrong");

  property p_x8_oe;
    state_reg == OFPI_READ && live && oct_reg |=> dq_oe == OE_OCTAL;
  endproperty
  a_x8_oe: assert property (p_x8_oe) else $error("x8 enables wrong");

  property p_int;
    event_in |=> int_n_oe && !int_n_out;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not sunk");

  c_txn:   cover property (sel_fall ##[1:300] sel_rise);
  c_read:  cover property (state_reg == OFPI_READ && launch_hit);
  c_int:   cover property (event_in && event_clear);
  c_init:  cover property (!init_n_s && sel_n_s);
endmodule
`default_nettype wire

//--- tb/ofpi_host.sv
// Purpose: Host model driving select, link clock and data lines.
// Assumes: Mode 0 clock of 160 ns, edges placed on sys_clk edges.
// Notes:   Released data lines flip every cycle.
`timescale 1ns/1ps
`default_nettype none
module ofpi_host (
  // Sampling clock
  input  wire logic       sys_clk,
  // Link pins from the host
  output logic            select_n,
  output logic            serial_clock,
  output logic      [7:0] dq_host
);
  logic [7:0] dq_val;
  logic       dq_en;
  logic [7:0] noise = 8'h5a;

  // Stale data must never pass for a real byte
  always @(posedge sys_clk) begin
    noise <= ~noise;
  end
  assign dq_host = dq_en ? dq_val : noise;

  initial begin
    select_n     = 1'b1;
    serial_clock = 1'b0;
    dq_val       = 8'h00;
    dq_en        = 1'b0;
  end

  // Frame edge with the clock parked low, still between frames
  task automatic frame(input logic on);
    @(posedge sys_clk);
    serial_clock <= 1'b0;
    select_n     <= ~on;
    repeat (7) @(posedge sys_clk);
  endtask

  // Half link period: data set up first so it is stable at the edge
  task automatic step(input logic drv, input logic [7:0] v, input logic lvl);
    @(posedge sys_clk);
    dq_en  <= drv;
    dq_val <= v;
    repeat (4) @(posedge sys_clk);
    serial_clock <= lvl;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- tb/ofpi_core_tb.sv
// Purpose: Self-checking bench for the flash pin interface core.
// Assumes: Host model makes the 160 ns link clock, in frames and once with select high.
// Notes:   A monitor counts one-cycle pulses; scenario tasks judge them.
`timescale 1ns/1ps
`default_nettype none
module ofpi_core_tb
  import ofpi_pkg::*;
;
  logic       sys_clk, rstn, hw_init_n, ddr_mode, octal_mode, op_busy;
  logic       event_in, event_clear, read_start, select_n, serial_clock;
  logic       read_strobe_out, read_strobe_oe, int_n_out, int_n_oe, int_line;
  logic       tx_take, rx_valid, txn_start, txn_end, standby, reinit;
  logic [7:0] tx_byte, dq_host, dq_line, dq_out, dq_oe, rx_byte;
  logic [7:0] rx_q[$];
  int         n_start, n_end, n_take, cyc, errors, checks;

  ofpi_host ofpi_host_inst (
    .sys_clk      (sys_clk),
    .select_n     (select_n),
    .serial_clock (serial_clock),
    .dq_host      (dq_host)
  );
  ofpi_core ofpi_core_inst (
    .sys_clk         (sys_clk),
    .rstn            (rstn),
    .select_n        (select_n),
    .serial_clock    (serial_clock),
    .dq_in           (dq_line),
    .hw_init_n       (hw_init_n),
    .dq_out          (dq_out),
    .dq_oe           (dq_oe),
    .read_strobe_out (read_strobe_out),
    .read_strobe_oe  (read_strobe_oe),
    .int_n_out       (int_n_out),
    .int_n_oe        (int_n_oe),
    .ddr_mode        (ddr_mode),
    .octal_mode      (octal_mode),
    .op_busy         (op_busy),
    .event_in        (event_in),
    .event_clear     (event_clear),
    .read_start      (read_start),
    .tx_byte         (tx_byte),
    .tx_take         (tx_take),
    .rx_byte         (rx_byte),
    .rx_valid        (rx_valid),
    .txn_start       (txn_start),
    .txn_end         (txn_end),
    .standby         (standby),
    .reinit          (reinit)
  );

  // Wire levels: enabled drivers win, pull-up on the interrupt line
  assign dq_line  = (dq_oe & dq_out) | (~dq_oe & dq_host);
  assign int_line = int_n_oe ? int_n_out : 1'b1;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chkb(input string what, input logic seen, input logic exp);
    chk(what, {7'h00, seen}, {7'h00, exp});
  endtask

  task automatic results();
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Pulses last one cycle, so count them as they pass; hang guard too
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
    if (txn_start === 1'b1) n_start++;
    if (txn_end === 1'b1) n_end++;
    if (tx_take === 1'b1) n_take++;
    if (int_n_oe === 1'b1) chkb("int_n_out", int_n_out, 1'b0);
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end

  // Land the edge's updates before looking
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic pulse_read();
    @(posedge sys_clk);
    read_start <= 1'b1;
    @(posedge sys_clk);
    read_start <= 1'b0;
  endtask

  task automatic t_reset();
    chkb("standby", standby, 1'b1);
    chk("dq_oe", dq_oe, OE_ALL_OFF);
    chkb("strobe_oe", read_strobe_oe, 1'b0);
    chkb("int_line", int_line, 1'b1);
  endtask

  // x8 capture: SDR keeps rising-edge bytes only, DDR keeps all four
  task automatic t_cap(input logic ddr);
    logic [7:0] v[4] = '{8'ha5, 8'h3c, 8'h96, 8'h69};
    @(posedge sys_clk);
    octal_mode <= 1'b1;
    ddr_mode   <= ddr;
    rx_q.delete();
    n_start = 0;
    n_end   = 0;
    ofpi_host_inst.frame(1'b1);
    for (int i = 0; i < 4; i++)
      ofpi_host_inst.step(1'b1, v[i], (i % 2) == 0);
    ofpi_host_inst.frame(1'b0);
    tick(4);
    chk("bytes", 8'(rx_q.size()), ddr ? 8'h04 : 8'h02);
    for (int i = 0; i < (ddr ? 4 : 2) && i < rx_q.size(); i++)
      chk("rx_byte", rx_q[i], ddr ? v[i] : v[2*i]);
    chk("starts", 8'(n_start), 8'h01);
    chk("ends", 8'(n_end), 8'h01);
  endtask

  // x1 capture on line 0, MSB first; trailing three bits dropped
  task automatic t_x1();
    logic [10:0] v = {8'hc5, 3'h5};
    @(posedge sys_clk);
    octal_mode <= 1'b0;
    ddr_mode   <= 1'b0;
    rx_q.delete();
    ofpi_host_inst.frame(1'b1);
    for (int i = 10; i >= 0; i--) begin
      ofpi_host_inst.step(1'b1, {7'h00, v[i]}, 1'b1);
      ofpi_host_inst.step(1'b1, {7'h00, v[i]}, 1'b0);
    end
    ofpi_host_inst.frame(1'b0);
    tick(4);
    chk("bytes", 8'(rx_q.size()), 8'h01);
    if (rx_q.size() > 0) chk("rx_byte", rx_q[0], 8'hc5);
  endtask

  // Read: launch edges, strobe in step, drivers off after select rises
  task automatic t_read(input logic oct, input logic ddr, input logic [7:0] oe_exp,
                        input logic [7:0] tx);
    logic st;
    @(posedge sys_clk);
    octal_mode <= oct;
    ddr_mode   <= ddr;
    tx_byte    <= tx;
    n_take = 0;
    ofpi_host_inst.frame(1'b1);
    chkb("standby", standby, 1'b0);
    ofpi_host_inst.step(1'b1, 8'h0b, 1'b1);
    ofpi_host_inst.step(1'b1, 8'h0b, 1'b0);
    pulse_read();
    tick(3);
    chk("dq_oe", dq_oe, oe_exp);
    chkb("strobe_oe", read_strobe_oe, 1'b1);
    st = read_strobe_out;
    ofpi_host_inst.step(1'b0, 8'h00, 1'b1);
    tick(2);
    chkb("strobe", read_strobe_out, st ^ ddr);
    ofpi_host_inst.step(1'b0, 8'h00, 1'b0);
    tick(2);
    chkb("strobe", read_strobe_out, ~(st ^ ddr));
    if (oct) chk("dq_out", dq_out, tx);
    else chkb("dq_out1", dq_out[SO_LINE], tx[7]);
    if (oct) chk("takes", 8'(n_take), ddr ? 8'h02 : 8'h01);
    ofpi_host_inst.frame(1'b0);
    tick(4);
    chk("dq_oe", dq_oe, OE_ALL_OFF);
    chkb("strobe_oe", read_strobe_oe, 1'b0);
  endtask

  // Clock activity with select high is ignored; standby waits on busy
  task automatic t_idle();
    rx_q.delete();
    n_start = 0;
    ofpi_host_inst.step(1'b1, 8'hff, 1'b1);
    ofpi_host_inst.step(1'b1, 8'hff, 1'b0);
    tick(2);
    chk("bytes", 8'(rx_q.size()), 8'h00);
    chk("starts", 8'(n_start), 8'h00);
    @(posedge sys_clk);
    op_busy <= 1'b1;
    tick(4);
    chkb("standby", standby, 1'b0);
    @(posedge sys_clk);
    op_busy <= 1'b0;
    tick(4);
    chkb("standby", standby, 1'b1);
  endtask

  // Initialisation pin during a live read, then with select high
  task automatic t_init();
    @(posedge sys_clk);
    octal_mode <= 1'b1;
    ofpi_host_inst.frame(1'b1);
    pulse_read();
    hw_init_n <= 1'b0;
    tick(5);
    chkb("reinit", reinit, 1'b1);
    chk("dq_oe", dq_oe, OE_ALL_OFF);
    chkb("strobe_oe", read_strobe_oe, 1'b0);
    ofpi_host_inst.frame(1'b0);
    tick(1);
    chkb("reinit", reinit, 1'b1);
    @(posedge sys_clk);
    hw_init_n <= 1'b1;
    tick(5);
    chkb("reinit", reinit, 1'b0);
  endtask

  // Event sinks the line, set beats clear, lone clear releases it
  task automatic t_int();
    @(posedge sys_clk);
    event_in <= 1'b1;
    @(posedge sys_clk);
    event_clear <= 1'b1;
    @(posedge sys_clk);
    event_in    <= 1'b0;
    event_clear <= 1'b0;
    tick(2);
    chkb("int_line", int_line, 1'b0);
    @(posedge sys_clk);
    event_clear <= 1'b1;
    @(posedge sys_clk);
    event_clear <= 1'b0;
    tick(2);
    chkb("int_line", int_line, 1'b1);
  endtask

  initial begin
    {rstn, ddr_mode, octal_mode, op_busy, event_in, event_clear, read_start} = '0;
    hw_init_n = 1'b1;
    tx_byte   = 8'h00;
    {n_start, n_end, n_take, cyc, errors, checks} = '0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(3);
    t_reset();
    t_cap(1'b0);
    t_cap(1'b1);
    t_x1();
    t_read(1'b1, 1'b0, OE_OCTAL, 8'hb4);
    t_read(1'b1, 1'b1, OE_OCTAL, 8'h5a);
    t_read(1'b0, 1'b0, OE_X1_SO, 8'hb4);
    t_idle();
    t_init();
    t_int();
    results();
  end
endmodule
`default_nettype wire
